// *** ebm_pkg.sv ***
package ebm_pkg;

   // operating modes as latched from the three mode-select pins (c,b,a)
   localparam logic [2:0] MODE_SSC = 3'h0;
   localparam logic [2:0] MODE_EEN = 3'h1;
   localparam logic [2:0] MODE_STEST = 3'h2;
   localparam logic [2:0] MODE_EEW = 3'h3;
   localparam logic [2:0] MODE_NSC = 3'h4;
   localparam logic [2:0] MODE_NEN = 3'h5;
   localparam logic [2:0] MODE_PERIPH = 3'h6;
   localparam logic [2:0] MODE_NEW = 3'h7;

   // register port
   localparam int REG_AW = 2;
   localparam logic [1:0] OFF_MODE = 2'h0;
   localparam logic [1:0] OFF_PORT_E_ASSIGN_REG = 2'h1;
   localparam logic [1:0] OFF_EXT_BUS_CTRL_REG = 2'h2;

   // mode register fields
   localparam int MODE_LSB = 5;
   localparam int MODE_INTERNAL_VISIBILITY_EN_BIT = 3;
   // port e assignment register fields
   localparam int PORT_E_ASSIGN_REG_NO_ACCESS_CYCLE_BIT = 7;
   localparam int PORT_E_ASSIGN_REG_PIPE_BIT = 5;
   localparam int PORT_E_ASSIGN_REG_BUS_CLOCK_OUT_DISABLE_BIT = 4;
   localparam int PORT_E_ASSIGN_REG_LOW_STROBE_EN_BIT = 3;
   localparam int PORT_E_ASSIGN_REG_READ_WRITE_PIN_EN_BIT = 2;
   // bus control register field
   localparam int EXT_BUS_CTRL_REG_BUS_CLOCK_STRETCH_EN_BIT = 0;

   // port e pin positions of the bus-control functions
   localparam int PE_NO_ACCESS_CYCLE = 7;
   localparam int PE_PIPE_HI = 6;
   localparam int PE_PIPE_LO = 5;
   localparam int PE_BUS_CLOCK_OUT = 4;
   localparam int PE_LOW_BYTE_STROBE = 3;
   localparam int PE_RW = 2;

   // cycles after reset release before the mode pins are taken
   localparam logic [1:0] CAPTURE_CYC = 2'h2;
   // default bus-clock stretch in clock cycles
   localparam int STRETCH_DEF = 1;
   // value of the mode register before capture
   localparam logic [2:0] MODE_RST = 3'h0;

   typedef enum logic [1:0] {BUS_IDLE, BUS_ADR, BUS_DAT} ebm_bus_e;

endpackage : ebm_pkg

// *** ebm_cfg.sv ***
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module ebm_cfg
#(
   parameter int STRETCH_CYC = ebm_pkg::STRETCH_DEF
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [ebm_pkg::REG_AW-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic mode_select_c,
   input wire logic mode_select_b,
   input wire logic mode_select_a,
   input wire logic bus_req,
   input wire logic [15:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_word,
   input wire logic bus_internal,
   output logic bus_ready,
   output logic bus_done,
   output logic [15:0] bus_rdata,
   input wire logic pipe_status_hi,
   input wire logic pipe_status_lo,
   input wire logic [7:0] gpio_a_out,
   input wire logic [7:0] gpio_a_dir,
   input wire logic [7:0] gpio_b_out,
   input wire logic [7:0] gpio_b_dir,
   input wire logic [7:0] gpio_e_out,
   input wire logic [7:0] gpio_e_dir,
   output logic [7:0] gpio_a_in,
   output logic [7:0] gpio_b_in,
   output logic [7:0] gpio_e_in,
   input wire logic [7:0] pa_in,
   output logic [7:0] pa_out,
   output logic [7:0] pa_oe,
   input wire logic [7:0] pb_in,
   output logic [7:0] pb_out,
   output logic [7:0] pb_oe,
   input wire logic [7:0] pe_in,
   output logic [7:0] pe_out,
   output logic [7:0] pe_oe,
   output logic pull_a_en,
   output logic pull_b_en,
   output logic [7:0] pull_e_en,
   output logic background_debug_state,
   output logic vector_fetch_en
);
   import ebm_pkg::*;

   if (STRETCH_CYC < 1 || STRETCH_CYC > 3)
   begin : g_bad_stretch
      $error("ebm_cfg: STRETCH_CYC must lie in 1..3");
   end

   typedef struct packed {
      logic [7:0] pa_s1;
      logic [7:0] pa_s2;
      logic [7:0] pb_s1;
      logic [7:0] pb_s2;
      logic [7:0] pe_s1;
      logic [7:0] pe_s2;
      logic [2:0] ms_s1;
      logic [2:0] ms_s2;
      logic [1:0] cap_cnt;
      logic cap;
      logic [2:0] mode;
      logic internal_visibility_en;
      logic mode_wr;
      logic no_access_cycle_en;
      logic pipe_en;
      logic bus_clock_out_disable;
      logic low_strobe_en;
      logic read_write_pin_en;
      logic port_e_assign_reg_wr;
      logic bus_clock_stretch_en;
      ebm_bus_e st;
      logic [1:0] scnt;
      logic split;
      logic second;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic write;
      logic word;
      logic internal;
      logic [15:0] rbuf;
      logic done;
      logic bus_clock_out;
      logic [7:0] rdata;
      logic [7:0] pa_o;
      logic [7:0] pa_e;
      logic [7:0] pb_o;
      logic [7:0] pb_e;
      logic [7:0] pe_o;
      logic [7:0] pe_e;
   } ebm_st_s;

   ebm_st_s r, n;

   ////////////////////////////////////////////////////////////////////////
   // mode decoding helpers

   function automatic logic f_single(input logic [2:0] m);
      f_single = (m == MODE_SSC) || (m == MODE_NSC);
   endfunction : f_single

   function automatic logic f_emul(input logic [2:0] m);
      f_emul = (m == MODE_EEN) || (m == MODE_EEW);
   endfunction : f_emul

   function automatic logic f_narrow(input logic [2:0] m);
      f_narrow = (m == MODE_EEN) || (m == MODE_NEN);
   endfunction : f_narrow

   function automatic logic f_special(input logic [2:0] m);
      f_special = (m == MODE_SSC) || (m == MODE_STEST);
   endfunction : f_special

   // visibility exists only in wide modes and emulation narrow
   function automatic logic f_vis_ok(input logic [2:0] m);
      f_vis_ok = (m == MODE_NEW) || (m == MODE_EEW) || (m == MODE_STEST) || (m == MODE_EEN);
   endfunction : f_vis_ok

   ////////////////////////////////////////////////////////////////////////
   // effective pin functions

   logic sc, emul, vis, pipe_eff, low_byte_strobe_eff, rw_eff, no_access_cycle_eff, bus_clock_out_eff;
   logic [7:0] fn_en, fn_val;

   // single-chip masks every bus-control enable except the bus clock output
   always_comb
   begin
      sc = f_single(r.mode);
      emul = f_emul(r.mode);
      vis = r.internal_visibility_en && f_vis_ok(r.mode);
      pipe_eff = !sc && (emul || r.pipe_en);
      low_byte_strobe_eff = !sc && (emul || r.low_strobe_en) && (r.mode != MODE_NEN);
      rw_eff = !sc && (emul || r.read_write_pin_en);
      no_access_cycle_eff = !sc && (emul || r.no_access_cycle_en);
      bus_clock_out_eff = emul || !r.bus_clock_out_disable;
      fn_en = {no_access_cycle_eff, pipe_eff, pipe_eff, bus_clock_out_eff, low_byte_strobe_eff, rw_eff, 2'b00};
      fn_val[PE_NO_ACCESS_CYCLE] = (r.st == BUS_IDLE);
      fn_val[PE_PIPE_HI] = pipe_status_hi;
      fn_val[PE_PIPE_LO] = pipe_status_lo;
      // bus clock rides with the pins: both are registered from the same state
      fn_val[PE_BUS_CLOCK_OUT] = sc ? r.bus_clock_out : (r.st == BUS_DAT);
      // active low: low for unsplit words and odd bytes
      fn_val[PE_LOW_BYTE_STROBE] = !(r.word && !r.split) && !r.addr[0];
      fn_val[PE_RW] = (r.st == BUS_IDLE) || !r.write;
      fn_val[1:0] = 2'b00;
   end

   ////////////////////////////////////////////////////////////////////////
   // next-state logic

   logic c_narrow;

   always_comb
   begin
      n = r;
      n.done = 1'b0;
      // pin synchronisers, first stage read only by the second
      n.pa_s1 = pa_in;
      n.pa_s2 = r.pa_s1;
      n.pb_s1 = pb_in;
      n.pb_s2 = r.pb_s1;
      n.pe_s1 = pe_in;
      n.pe_s2 = r.pe_s1;
      n.ms_s1 = {mode_select_c, mode_select_b, mode_select_a};
      n.ms_s2 = r.ms_s1;
      // narrow byte lanes unless a visible internal cycle
      c_narrow = f_narrow(r.mode) && !r.internal;

      // take mode pins once the synchroniser holds them
      if (!r.cap)
      begin
         n.cap_cnt = r.cap_cnt + 2'h1;
         if (r.cap_cnt == CAPTURE_CYC)
         begin
            n.cap = 1'b1;
            n.mode = r.ms_s2;
            n.no_access_cycle_en = f_emul(r.ms_s2);
            n.pipe_en = f_emul(r.ms_s2);
            n.low_strobe_en = f_emul(r.ms_s2);
            n.read_write_pin_en = f_emul(r.ms_s2);
            n.bus_clock_out_disable = (r.ms_s2 == MODE_NSC);
            n.bus_clock_stretch_en = !f_special(r.ms_s2);
         end
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            OFF_MODE:
            begin
               if (f_special(r.mode))
               begin
                  if (reg_wdata[MODE_LSB+:3] != MODE_PERIPH)
                  begin
                     n.mode = reg_wdata[MODE_LSB+:3];
                  end
                  n.internal_visibility_en = reg_wdata[MODE_INTERNAL_VISIBILITY_EN_BIT];
               end
               // one write, only towards normal expanded
               else if (r.mode == MODE_NSC && !r.mode_wr)
               begin
                  n.mode_wr = 1'b1;
                  n.internal_visibility_en = reg_wdata[MODE_INTERNAL_VISIBILITY_EN_BIT];
                  if (reg_wdata[MODE_LSB+:3] == MODE_NEN || reg_wdata[MODE_LSB+:3] == MODE_NEW)
                  begin
                     n.mode = reg_wdata[MODE_LSB+:3];
                  end
               end
            end
            OFF_PORT_E_ASSIGN_REG:
            begin
               // emulation ignores enable writes; narrow writes once
               if (!f_emul(r.mode) && !(r.mode == MODE_NEN && r.port_e_assign_reg_wr && !f_special(r.mode)))
               begin
                  n.port_e_assign_reg_wr = 1'b1;
                  n.no_access_cycle_en = reg_wdata[PORT_E_ASSIGN_REG_NO_ACCESS_CYCLE_BIT];
                  n.pipe_en = reg_wdata[PORT_E_ASSIGN_REG_PIPE_BIT];
                  n.bus_clock_out_disable = reg_wdata[PORT_E_ASSIGN_REG_BUS_CLOCK_OUT_DISABLE_BIT];
                  n.low_strobe_en = reg_wdata[PORT_E_ASSIGN_REG_LOW_STROBE_EN_BIT];
                  n.read_write_pin_en = reg_wdata[PORT_E_ASSIGN_REG_READ_WRITE_PIN_EN_BIT];
               end
            end
            OFF_EXT_BUS_CTRL_REG:
            begin
               n.bus_clock_stretch_en = reg_wdata[EXT_BUS_CTRL_REG_BUS_CLOCK_STRETCH_EN_BIT];
            end
            default:
            begin
               n.bus_clock_stretch_en = r.bus_clock_stretch_en;
            end
         endcase
      end

      // read data stands the cycle after the strobe
      n.rdata = 8'h00;
      if (reg_rd)
      begin
         unique case (reg_addr)
            OFF_MODE: n.rdata = 8'((r.mode << MODE_LSB) | (vis << MODE_INTERNAL_VISIBILITY_EN_BIT));
            OFF_PORT_E_ASSIGN_REG: n.rdata = 8'((r.no_access_cycle_en << PORT_E_ASSIGN_REG_NO_ACCESS_CYCLE_BIT)
               | (r.pipe_en << PORT_E_ASSIGN_REG_PIPE_BIT) | (r.bus_clock_out_disable << PORT_E_ASSIGN_REG_BUS_CLOCK_OUT_DISABLE_BIT)
               | (r.low_strobe_en << PORT_E_ASSIGN_REG_LOW_STROBE_EN_BIT) | (r.read_write_pin_en << PORT_E_ASSIGN_REG_READ_WRITE_PIN_EN_BIT));
            OFF_EXT_BUS_CTRL_REG: n.rdata = 8'(r.bus_clock_stretch_en << EXT_BUS_CTRL_REG_BUS_CLOCK_STRETCH_EN_BIT);
            default: n.rdata = 8'h00;
         endcase
      end

      // bus cycle sequencer
      unique case (r.st)
         BUS_IDLE:
         begin
            if (bus_req && r.cap)
            begin
               n.addr = bus_addr;
               n.wdata = bus_wdata;
               n.write = bus_write;
               n.word = bus_word;
               n.internal = bus_internal;
               n.second = 1'b0;
               n.rbuf = 16'h0000;
               // hidden internal cycles and single-chip stay off the pins
               if (sc || (bus_internal && !vis))
               begin
                  n.done = 1'b1;
               end
               else
               begin
                  // external word in narrow mode goes as two bytes
                  n.split = f_narrow(r.mode) && bus_word && !bus_internal;
                  n.st = BUS_ADR;
               end
            end
         end
         BUS_ADR:
         begin
            n.scnt = r.bus_clock_stretch_en ? 2'(STRETCH_CYC) : 2'h0;
            n.st = BUS_DAT;
         end
         BUS_DAT:
         begin
            if (r.scnt != 2'h0)
            begin
               n.scnt = r.scnt - 2'h1;
            end
            else
            begin
               // narrow bytes come back on port a
               if (!c_narrow)
               begin
                  n.rbuf = {r.pa_s2, r.pb_s2};
               end
               else if (r.addr[0])
               begin
                  n.rbuf[7:0] = r.pa_s2;
               end
               else
               begin
                  n.rbuf[15:8] = r.pa_s2;
               end
               if (r.split && !r.second)
               begin
                  n.second = 1'b1;
                  n.addr = r.addr + 16'h0001;
                  n.st = BUS_ADR;
               end
               else
               begin
                  n.done = 1'b1;
                  n.st = BUS_IDLE;
               end
            end
         end
         default:
         begin
            n.st = BUS_IDLE;
         end
      endcase

      // free-running in single-chip, high in the data phase otherwise
      n.bus_clock_out = sc ? !r.bus_clock_out : (r.st == BUS_DAT);

      // single-chip ports a and b are gpio
      if (sc || !r.cap)
      begin
         n.pa_o = gpio_a_out;
         n.pa_e = gpio_a_dir;
         n.pb_o = gpio_b_out;
         n.pb_e = gpio_b_dir;
      end
      else if (r.st == BUS_ADR)
      begin
         n.pa_o = r.addr[15:8];
         n.pb_o = r.addr[7:0];
         n.pa_e = 8'hff;
         n.pb_e = 8'hff;
      end
      else if (r.st == BUS_DAT)
      begin
         // narrow: data on a, address low byte held on b
         if (c_narrow)
         begin
            n.pa_o = r.addr[0] ? r.wdata[7:0] : r.wdata[15:8];
            n.pa_e = {8{r.write}};
         end
         else
         begin
            n.pa_o = r.wdata[15:8];
            n.pb_o = r.wdata[7:0];
            n.pa_e = {8{r.write}};
            n.pb_e = {8{r.write}};
         end
      end

      // each port e pin is either its function or plain gpio
      n.pe_o = (fn_en & fn_val) | (~fn_en & gpio_e_out);
      n.pe_e = fn_en | (~fn_en & gpio_e_dir & 8'hfc);
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         r <= '{st: BUS_IDLE, mode: MODE_RST, default: '0};
      end
      else
      begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   // pulls only on undriven port e pins, never on a or b
   assign pull_a_en = 1'b0;
   assign pull_b_en = 1'b0;
   assign pull_e_en = ~r.pe_e;
   assign pa_out = r.pa_o;
   assign pa_oe = r.pa_e;
   assign pb_out = r.pb_o;
   assign pb_oe = r.pb_e;
   assign pe_out = r.pe_o;
   assign pe_oe = r.pe_e;
   assign gpio_a_in = r.pa_s2;
   assign gpio_b_in = r.pb_s2;
   assign gpio_e_in = r.pe_s2;
   assign reg_rdata = r.rdata;
   assign bus_ready = (r.st == BUS_IDLE) && r.cap;
   assign bus_done = r.done;
   assign bus_rdata = r.rbuf;
   // debug owns the core in special single-chip
   assign background_debug_state = r.cap && (r.mode == MODE_SSC);
   assign vector_fetch_en = r.cap && (r.mode != MODE_SSC);

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   property p_pe10_in;
      r.cap |-> (pe_oe[1:0] == 2'b00) && (pull_e_en[1:0] == 2'b11);
   endproperty
   a_pe10_in: assert property (p_pe10_in) else $error("pe1/pe0 driven");

   property p_sc_ctl;
      (r.cap && f_single(r.mode) && !reg_wr) |=> (pe_oe[3:2] == $past(gpio_e_dir[3:2]));
   endproperty
   a_sc_ctl: assert property (p_sc_ctl) else $error("single-chip control pin");

   property p_once;
      (r.cap && r.mode == MODE_NSC && r.mode_wr && reg_wr && reg_addr == OFF_MODE)
         |=> (r.mode == MODE_NSC);
   endproperty
   a_once: assert property (p_once) else $error("second mode write took");

   property p_sc_bus_clock_out;
      (r.cap && f_single(r.mode) && !r.bus_clock_out_disable && !reg_wr) |=> ##1 pe_oe[PE_BUS_CLOCK_OUT];
   endproperty
   a_sc_bus_clock_out: assert property (p_sc_bus_clock_out) else $error("no bus clock out");

   property p_wide_adr;
      (r.st == BUS_ADR) |=> (pa_oe == 8'hff) && (pb_oe == 8'hff) && (pa_out == $past(r.addr[15:8]));
   endproperty
   a_wide_adr: assert property (p_wide_adr) else $error("address not driven");

   property p_nen_strobe;
      (r.cap && r.mode == MODE_NEN && !reg_wr) |=> (pe_oe[3] == $past(gpio_e_dir[3]));
   endproperty
   a_nen_strobe: assert property (p_nen_strobe) else $error("strobe in narrow");

   sequence s_first_half;
      (r.st == BUS_ADR) && r.split && !r.second;
   endsequence
   sequence s_second_half;
      (r.st == BUS_ADR) && r.second;
   endsequence
   property p_split;
      // one address cycle, then one to four data cycles
      s_first_half |-> ##[2:5] s_second_half;
   endproperty
   a_split: assert property (p_split) else $error("word not split");

   property p_bus_clock_stretch_en;
      ($rose(r.cap) && !f_special(r.mode)) |-> r.bus_clock_stretch_en;
   endproperty
   a_bus_clock_stretch_en: assert property (p_bus_clock_stretch_en) else $error("stretch not set");

   property p_bdm;
      ($rose(r.cap) && r.mode == MODE_SSC) |-> background_debug_state && !vector_fetch_en;
   endproperty
   a_bdm: assert property (p_bdm) else $error("debug not active");

endmodule : ebm_cfg

// *** ebm_ext_mem.sv ***
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// far-side memory: fixed read bytes, records the last write it saw
module ebm_ext_mem
#(
   parameter logic [7:0] RD_A = 8'hc3,
   parameter logic [7:0] RD_B = 8'h69
)
(
   input wire logic clock,
   input wire logic [7:0] pa_out,
   input wire logic [7:0] pa_oe,
   input wire logic [7:0] pb_out,
   input wire logic [7:0] pb_oe,
   input wire logic [7:0] pe_out,
   input wire logic [7:0] pe_oe,
   output logic [7:0] pa_in,
   output logic [7:0] pb_in,
   output logic [7:0] pe_in,
   output logic [15:0] last_wr
);
   ////////////////////////////////////////////////////////////////////////////////
   // high byte on port a
   // driven level wins, released lines carry the memory's answer
   assign pa_in = (pa_oe & pa_out) | (~pa_oe & RD_A);
   assign pb_in = (pb_oe & pb_out) | (~pb_oe & RD_B);
   // port e lines are pulled up once released
   assign pe_in = (pe_oe & pe_out) | ~pe_oe;

   // data phase capture
   // last cycle of clock high with both ports driven holds write data
   always @(posedge clock)
   begin
      if (pe_out[4] && (&pa_oe) && (&pb_oe))
      begin
         last_wr <= {pa_out, pb_out};
      end
   end
endmodule : ebm_ext_mem

// *** ebm_cfg_tb.sv ***
`timescale 1ns/1ns
module ebm_cfg_tb;
   import ebm_pkg::*;
   logic clock, sys_rst, reg_wr, reg_rd, bus_req, bus_write, bus_word, bus_internal;
   logic mode_select_c, mode_select_b, mode_select_a, pipe_status_hi, pipe_status_lo;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, gpio_a_out, gpio_a_dir, gpio_b_out, gpio_b_dir;
   logic [7:0] gpio_e_out, gpio_e_dir, gpio_a_in, gpio_b_in, gpio_e_in, pa_in, pa_out;
   logic [7:0] pa_oe, pb_in, pb_out, pb_oe, pe_in, pe_out, pe_oe, pull_e_en, d, oe_exp;
   logic [15:0] bus_addr, bus_wdata, bus_rdata, last_wr;
   logic bus_ready, bus_done, pull_a_en, pull_b_en, background_debug_state, vector_fetch_en;
   logic emu;
   int fail_count, checks, cyc;

   // long stretch: 3 is the least that lets the synchronised read sample reach the released window
   ebm_cfg #(.STRETCH_CYC(3)) u_dut (.*);
   ebm_ext_mem u_mem (.*);

   ////////////////////////////////////////////////////////////////////////////////
   // 50 ns clock
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task close_out;
      if (fail_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // one-cycle strobes, changed just after the edge
   task wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr

   task rd(input logic [1:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   // request held through the taking edge, then a bounded wait for done
   task bx(input logic [15:0] a, input logic [15:0] v, input logic w);
      int n;
      @(posedge clock);
      bus_addr <= a;
      bus_wdata <= v;
      bus_write <= w;
      bus_word <= 1'b1;
      bus_req <= 1'b1;
      @(posedge clock);
      bus_req <= 1'b0;
      #1;
      n = 0;
      while (bus_done !== 1'b1 && n < 40)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      chk("bus_done", {15'h0, bus_done}, 16'h1);
   endtask : bx

   // pins stable across the whole reset and well after release
   task do_reset(input logic [2:0] m);
      @(posedge clock);
      {mode_select_c, mode_select_b, mode_select_a} <= m;
      sys_rst <= 1'b1;
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clock);
      #1;
   endtask : do_reset

   task settle;
      repeat (3) @(posedge clock);
      #1;
   endtask : settle

   ////////////////////////////////////////////////////////////////////////////////
   // hang guard, far above the expected run length
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fail_count++;
         close_out;
      end
   end

   // main sequence
   initial
   begin
      {sys_rst, reg_wr, reg_rd, bus_req, bus_write, bus_word, bus_internal} = 7'h40;
      {mode_select_c, mode_select_b, mode_select_a, pipe_status_hi, pipe_status_lo} = 5'h0;
      {reg_addr, reg_wdata, bus_addr, bus_wdata} = 42'h0;
      {gpio_a_out, gpio_a_dir, gpio_b_out, gpio_b_dir, gpio_e_out, gpio_e_dir} = 48'h0;
      {fail_count, checks, cyc} = '0;
      // reset state of every usable mode
      for (int i = 0; i < 8; i++)
      begin
         if (i != 6)
         begin
            do_reset(i[2:0]);
            emu = (i == 1 || i == 3);
            oe_exp = emu ? 8'hfc : (i == 4 ? 8'h00 : 8'h10);
            rd(OFF_MODE);
            chk("mode", d, {i[2:0], 5'h0});
            rd(OFF_EXT_BUS_CTRL_REG);
            chk("stretch", d[0], !(i == 0 || i == 2));
            rd(OFF_PORT_E_ASSIGN_REG);
            chk("port_e_assign_reg", d & 8'hbc, emu ? 8'hac : (i == 4 ? 8'h10 : 8'h00));
            chk("pe_oe", pe_oe, oe_exp);
            chk("pull_e", {8'h00, pull_e_en}, {8'h00, ~oe_exp});
            chk("pull_ab", {pull_a_en, pull_b_en}, 2'b00);
            chk("debug", {background_debug_state, vector_fetch_en}, i == 0 ? 2'b10 : 2'b01);
            chk("ready", bus_ready, 1'b1);
         end
      end
      // normal single-chip: enables masked, clock freed, mode written once
      do_reset(MODE_NSC);
      wr(OFF_PORT_E_ASSIGN_REG, 8'h2c);
      gpio_a_dir <= 8'hff;
      gpio_a_out <= 8'h3c;
      gpio_e_dir <= 8'h0c;
      gpio_e_out <= 8'h08;
      settle;
      chk("pa", {pa_oe, pa_out}, 16'hff3c);
      chk("gpio_a_in", gpio_a_in, 8'h3c);
      chk("gpio_b_in", gpio_b_in, 8'h69);
      chk("gpio_e_in", gpio_e_in & 8'hef, 8'heb);
      chk("pe_oe_sc", pe_oe, 8'h1c);
      chk("pe_gpio", pe_out[3:2], 2'b10);
      d[0] = pe_out[4];
      @(posedge clock);
      #1;
      chk("bus_clock_out", pe_out[4] ^ d[0], 1'b1);
      gpio_a_dir <= 8'h00;
      gpio_e_dir <= 8'h00;
      wr(OFF_MODE, 8'h88);
      wr(OFF_MODE, 8'he8);
      rd(OFF_MODE);
      chk("mode_once", d, 8'h80);
      do_reset(MODE_NSC);
      wr(OFF_MODE, 8'he8);
      rd(OFF_MODE);
      chk("mode_exp", d, 8'he8);
      // normal wide: enables take effect, bus traffic both ways
      do_reset(MODE_NEW);
      // read/write enable set ahead of external writes
      wr(OFF_PORT_E_ASSIGN_REG, 8'h2c);
      pipe_status_hi <= 1'b1;
      settle;
      chk("pe_oe_new", pe_oe, 8'h7c);
      chk("pipe", pe_out[6:5], 2'b10);
      bx(16'h1234, 16'h5aa5, 1'b1);
      chk("wr_word", last_wr, 16'h5aa5);
      bx(16'h1234, 16'h0000, 1'b0);
      chk("rd_word", bus_rdata, 16'hc369);
      // normal narrow: one assignment write, strobe overridden, split words
      do_reset(MODE_NEN);
      wr(OFF_PORT_E_ASSIGN_REG, 8'h0c);
      wr(OFF_PORT_E_ASSIGN_REG, 8'h20);
      rd(OFF_PORT_E_ASSIGN_REG);
      chk("port_e_assign_reg_once", d & 8'hbc, 8'h0c);
      settle;
      chk("pe_oe_nen", pe_oe, 8'h14);
      bx(16'h2000, 16'h0000, 1'b0);
      chk("rd_narrow", bus_rdata, 16'hc3c3);
      // emulation: assignment writes refused
      do_reset(MODE_EEN);
      wr(OFF_PORT_E_ASSIGN_REG, 8'h00);
      rd(OFF_PORT_E_ASSIGN_REG);
      chk("port_e_assign_reg_emu", d & 8'hbc, 8'hac);
      // hidden internal write must leave the far side untouched
      bus_internal <= 1'b1;
      bx(16'h3000, 16'h1111, 1'b1);
      chk("hidden", last_wr, 16'h5aa5);
      bus_internal <= 1'b0;
      // special test: repeated mode writes accepted, unmapped reads zero
      do_reset(MODE_STEST);
      wr(OFF_MODE, 8'h48);
      wr(OFF_MODE, 8'ha0);
      rd(OFF_MODE);
      chk("mode_test", d, 8'ha0);
      rd(2'h3);
      chk("unmapped", d, 8'h00);
      close_out;
   end
endmodule : ebm_cfg_tb
